// ---- mlsi_pkg.sv ----
package mlsi_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned GREEN_MS        = 200;
  localparam int unsigned YELLOW_MS       = 200;
  localparam int unsigned RED_MS          = 1000;
  localparam int unsigned CONTEND_MS      = 1000;
  localparam int unsigned GREEN_CYC       = CLK_HZ / 1000 * GREEN_MS;
  localparam int unsigned YELLOW_CYC      = CLK_HZ / 1000 * YELLOW_MS;
  localparam int unsigned RED_CYC         = CLK_HZ / 1000 * RED_MS;
  localparam int unsigned CONTEND_CYC     = CLK_HZ / 1000 * CONTEND_MS;
  localparam int unsigned TMR_W           = 25;
  localparam int unsigned MAX_FRAME_BYTES = 256;
  localparam int unsigned CNT_W           = 16;
  localparam logic [7:0]  ADDR_BCAST      = 8'h00;
  localparam logic [7:0]  ADDR_MIN        = 8'h01;
  localparam logic [7:0]  ADDR_MAX        = 8'hf7;
  localparam logic [8:0]  LEN_RESET       = 9'h000;
  localparam logic [CNT_W-1:0] CNT_RESET  = 16'h0000;

  typedef enum logic [3:0] {
    MLSI_ERR_NONE    = 4'h0,
    MLSI_ERR_CRC     = 4'h1,
    MLSI_ERR_FRAMING = 4'h2,
    MLSI_ERR_OVERRUN = 4'h3,
    MLSI_ERR_PARSE   = 4'h4,
    MLSI_ERR_REQUEST = 4'h5
  } mlsi_err_t;

  typedef enum logic [2:0] {
    MLSI_LAMP_OFF     = 3'b000,
    MLSI_LAMP_GREEN   = 3'b001,
    MLSI_LAMP_YELLOW  = 3'b010,
    MLSI_LAMP_RED     = 3'b011,
    MLSI_LAMP_CONTEND = 3'b100
  } mlsi_lamp_t;
endpackage

// ---- mlsi_lamp_timer.sv ----
`timescale 1ns/1ps
module mlsi_lamp_timer
  import mlsi_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_load,
  input  wire mlsi_lamp_t       i_colour,
  input  wire logic [TMR_W-1:0] i_cycles,
  input  wire logic             i_hold,
  output logic                  o_red,
  output logic                  o_green
);
  mlsi_lamp_t       lamp_q;
  logic [TMR_W-1:0] tmr_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lamp_q <= MLSI_LAMP_OFF;
      tmr_q  <= '0;
    end else if (i_load) begin
      lamp_q <= i_colour;
      tmr_q  <= i_cycles;
    end else if (tmr_q > 1 || (i_hold && lamp_q == MLSI_LAMP_YELLOW)) begin
      tmr_q  <= (tmr_q > 1) ? tmr_q - 1'b1 : tmr_q;
    end else begin
      lamp_q <= MLSI_LAMP_OFF;
      tmr_q  <= '0;
    end
  end

  // bicolour lamp: yellow is red plus green
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_red   <= 1'b0;
      o_green <= 1'b0;
    end else begin
      unique case (lamp_q)
        MLSI_LAMP_OFF: begin
          o_red   <= 1'b0;
          o_green <= 1'b0;
        end
        MLSI_LAMP_GREEN: begin
          o_red   <= 1'b0;
          o_green <= 1'b1;
        end
        MLSI_LAMP_YELLOW: begin
          o_red   <= 1'b1;
          o_green <= 1'b1;
        end
        MLSI_LAMP_RED: begin
          o_red   <= 1'b1;
          o_green <= 1'b0;
        end
        MLSI_LAMP_CONTEND: begin
          o_red   <= tmr_q[21];
          o_green <= 1'b1;
        end
        default: begin
          o_red   <= 1'b0;
          o_green <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- mlsi_status.sv ----
`timescale 1ns/1ps
// What this block does
// - lamp dark while the bus is idle
// - own good frame lights green 200 ms
// - foreign frame yellow 200 ms or frame length
// - bus activity during reply prep shows contention
// - invalid frame lights red one second
// - invalid frame stores matching error code
// - failed checksum is an invalid frame
// - character framing failure is an invalid frame
// - frame over 256 bytes is overrun error
// - undecodable frame is a parse error
// - unservable request gives exception, stores code
// - invalid request on valid frame stays green
// - other errors store code but raise no exception
// - separate tallies for four error kinds
// - addresses 1..247 unicast, 0 broadcast
module mlsi_status
  import mlsi_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_rx_line,
  input  wire logic [7:0]       i_own_addr,
  input  wire logic             i_byte_valid,
  input  wire logic             i_byte_framing_err,
  input  wire logic             i_frame_start,
  input  wire logic             i_frame_end,
  input  wire logic [7:0]       i_frame_addr,
  input  wire logic             i_crc_ok,
  input  wire logic             i_parse_ok,
  input  wire logic             i_request_ok,
  input  wire logic             i_reply_prep,
  output logic                  o_lamp_red,
  output logic                  o_lamp_green,
  output logic                  o_exception_req,
  output logic                  o_reply_abort,
  output logic [3:0]            o_error_code_store,
  output logic [CNT_W-1:0]      o_checksum_fail_tally,
  output logic [CNT_W-1:0]      o_char_framing_fail_tally,
  output logic [CNT_W-1:0]      o_frame_parse_fail_tally,
  output logic [CNT_W-1:0]      o_buffer_overflow_tally
);
  function automatic logic addr_is_ours(input logic [7:0] a, input logic [7:0] own);
    addr_is_ours = (a == ADDR_BCAST) ||
                   (a >= ADDR_MIN && a <= ADDR_MAX && a == own);
  endfunction

  logic             rx_s1_q;
  logic             rx_s2_q;
  logic             rx_prev_q;
  logic             in_frame_q;
  logic             frame_err_q;
  logic [8:0]       len_q;
  logic             overrun_q;
  logic             load;
  mlsi_lamp_t       colour;
  logic [TMR_W-1:0] cycles;
  logic             bad_frame;
  logic             own_frame;
  logic             bus_edge;
  logic             byte_bad;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q   <= i_rx_line;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  assign bus_edge = rx_prev_q != rx_s2_q;

  // frame open between start and end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      in_frame_q <= 1'b0;
    end else if (i_frame_start) begin
      in_frame_q <= 1'b1;
    end else if (i_frame_end) begin
      in_frame_q <= 1'b0;
    end
  end

  assign byte_bad = i_byte_valid && i_byte_framing_err;

  // a byte landing with the start belongs to the new frame
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      frame_err_q <= 1'b0;
    end else if (i_frame_start) begin
      frame_err_q <= byte_bad;
    end else if (byte_bad) begin
      frame_err_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      len_q     <= LEN_RESET;
      overrun_q <= 1'b0;
    end else if (i_frame_start) begin
      len_q     <= i_byte_valid ? 9'h001 : LEN_RESET;
      overrun_q <= 1'b0;
    end else if (i_byte_valid) begin
      if (len_q == 9'(MAX_FRAME_BYTES)) begin
        overrun_q <= 1'b1;
      end else begin
        len_q <= len_q + 9'h001;
      end
    end
  end

  assign bad_frame = frame_err_q || overrun_q || !i_crc_ok || !i_parse_ok;
  assign own_frame = addr_is_ours(i_frame_addr, i_own_addr);

  // contention relies on others releasing the bus promptly
  always_comb begin
    load   = 1'b0;
    colour = MLSI_LAMP_OFF;
    cycles = '0;
    if (i_reply_prep && bus_edge) begin
      load   = 1'b1;
      colour = MLSI_LAMP_CONTEND;
      cycles = TMR_W'(CONTEND_CYC);
    end else if (i_frame_end && bad_frame) begin
      load   = 1'b1;
      colour = MLSI_LAMP_RED;
      cycles = TMR_W'(RED_CYC);
    end else if (i_frame_end && own_frame) begin
      load   = 1'b1;
      colour = MLSI_LAMP_GREEN;
      cycles = TMR_W'(GREEN_CYC);
    end else if (i_frame_start && !own_frame) begin
      load   = 1'b1;
      colour = MLSI_LAMP_YELLOW;
      cycles = TMR_W'(YELLOW_CYC);
    end
  end

  mlsi_lamp_timer u_timer (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_load   (load),
    .i_colour (colour),
    .i_cycles (cycles),
    .i_hold   (in_frame_q),
    .o_red    (o_lamp_red),
    .o_green  (o_lamp_green)
  );

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_error_code_store <= MLSI_ERR_NONE;
    end else if (i_frame_end && frame_err_q) begin
      o_error_code_store <= MLSI_ERR_FRAMING;
    end else if (i_frame_end && overrun_q) begin
      o_error_code_store <= MLSI_ERR_OVERRUN;
    end else if (i_frame_end && !i_crc_ok) begin
      o_error_code_store <= MLSI_ERR_CRC;
    end else if (i_frame_end && !i_parse_ok) begin
      o_error_code_store <= MLSI_ERR_PARSE;
    end else if (i_frame_end && own_frame && !i_request_ok) begin
      o_error_code_store <= MLSI_ERR_REQUEST;
    end
  end

  // exception request for a good frame with an unservable request
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_exception_req <= 1'b0;
    end else begin
      o_exception_req <= i_frame_end && !bad_frame && own_frame && !i_request_ok;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_reply_abort <= 1'b0;
    end else begin
      o_reply_abort <= i_reply_prep && bus_edge;
    end
  end

  // tallies wrap; each judged on the frame end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_checksum_fail_tally <= CNT_RESET;
    end else if (i_frame_end && !i_crc_ok) begin
      o_checksum_fail_tally <= o_checksum_fail_tally + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_char_framing_fail_tally <= CNT_RESET;
    end else if (i_frame_end && frame_err_q) begin
      o_char_framing_fail_tally <= o_char_framing_fail_tally + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_frame_parse_fail_tally <= CNT_RESET;
    end else if (i_frame_end && i_crc_ok && !i_parse_ok) begin
      o_frame_parse_fail_tally <= o_frame_parse_fail_tally + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_buffer_overflow_tally <= CNT_RESET;
    end else if (i_frame_end && overrun_q) begin
      o_buffer_overflow_tally <= o_buffer_overflow_tally + 1'b1;
    end
  end
endmodule

// ---- mlsi_status_assertions.sv ----
`timescale 1ns/1ps
module mlsi_status_assertions (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_rx_line,
  input wire logic [7:0]  i_own_addr,
  input wire logic        i_byte_valid,
  input wire logic        i_byte_framing_err,
  input wire logic        i_frame_start,
  input wire logic        i_frame_end,
  input wire logic [7:0]  i_frame_addr,
  input wire logic        i_crc_ok,
  input wire logic        i_parse_ok,
  input wire logic        i_request_ok,
  input wire logic        i_reply_prep,
  input wire logic        o_lamp_red,
  input wire logic        o_lamp_green,
  input wire logic        o_exception_req,
  input wire logic        o_reply_abort,
  input wire logic [3:0]  o_error_code_store,
  input wire logic [15:0] o_checksum_fail_tally,
  input wire logic [15:0] o_char_framing_fail_tally,
  input wire logic [15:0] o_frame_parse_fail_tally,
  input wire logic [15:0] o_buffer_overflow_tally
);
  logic       bad_q;
  logic [9:0] n_q;
  logic       ok;
  logic       own;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bad_q <= 1'b0;
      n_q   <= 10'h000;
    end else if (i_frame_start) begin
      bad_q <= i_byte_valid && i_byte_framing_err;
      n_q   <= {9'h000, i_byte_valid};
    end else if (i_byte_valid) begin
      bad_q <= bad_q | i_byte_framing_err;
      n_q   <= n_q + 10'h001;
    end
  end
  assign ok  = i_frame_end && !bad_q && n_q <= 10'h100;
  assign own = i_frame_addr == 8'h00 || (i_frame_addr == i_own_addr
    && i_own_addr >= 8'h01 && i_own_addr <= 8'hf7);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_own_green: assert property (ok && own && i_crc_ok && i_parse_ok
    |-> ##3 o_lamp_green && !o_lamp_red) else $error("own frame not green");
  a_other_yellow: assert property (i_frame_start && !own
    |-> ##3 o_lamp_green && o_lamp_red) else $error("foreign frame not yellow");
  a_crc_red: assert property (ok && !i_crc_ok |-> ##2 o_error_code_store == 4'h1
    && o_checksum_fail_tally == $past(o_checksum_fail_tally, 2) + 16'h0001
    ##1 o_lamp_red && !o_lamp_green) else $error("checksum fault mishandled");
  a_frame_code: assert property (i_frame_end && bad_q
    |-> ##2 o_error_code_store == 4'h2
    && o_char_framing_fail_tally == $past(o_char_framing_fail_tally, 2) + 16'h0001
    ##1 o_lamp_red) else $error("framing fault code");
  a_overrun_code: assert property (i_frame_end && !bad_q && n_q > 10'h100
    |-> ##2 o_error_code_store == 4'h3
    && o_buffer_overflow_tally == $past(o_buffer_overflow_tally, 2) + 16'h0001)
    else $error("overrun code");
  a_parse_code: assert property (ok && i_crc_ok && !i_parse_ok
    |-> ##2 o_error_code_store == 4'h4
    && o_frame_parse_fail_tally == $past(o_frame_parse_fail_tally, 2) + 16'h0001)
    else $error("parse code");
  a_exception_pulse: assert property (ok && own && i_crc_ok && i_parse_ok
    |=> o_exception_req == !$past(i_request_ok)) else $error("exception mismatch");
  a_idle_dark: assert property (!o_lamp_red && !o_lamp_green && !$past(i_frame_start)
    && !$past(i_frame_end) && !$past(i_reply_prep) |=> !o_lamp_red && !o_lamp_green)
    else $error("lamp lit while idle");
  a_contend_abort: assert property (i_reply_prep && $fell(i_rx_line)
    |-> ##[3:8] o_reply_abort) else $error("no reply abort");
endmodule
bind mlsi_status mlsi_status_assertions u_chk (.*);

// ---- mlsi_master_model.sv ----
`timescale 1ns/1ps
module mlsi_master_model (
  input  wire logic  i_clk,
  output logic       o_rx,
  output logic       o_start,
  output logic       o_bv,
  output logic       o_ferr,
  output logic       o_end,
  output logic       o_crc,
  output logic       o_parse,
  output logic       o_req,
  output logic [7:0] o_addr
);
  initial {o_rx, o_start, o_bv, o_ferr, o_end, o_crc, o_parse, o_req, o_addr} = 16'h8000;
  task automatic send(input logic [7:0] a, input int n, input logic fe, c, p, r);
    @(posedge i_clk) #1 {o_start, o_addr} = {1'b1, a};
    @(posedge i_clk) #1 {o_start, o_bv, o_ferr} = {2'b01, fe};
    repeat (n) @(posedge i_clk) #1 o_ferr = 1'b0;
    {o_bv, o_end, o_crc, o_parse, o_req} = {2'b01, c, p, r};
    @(posedge i_clk) #1 {o_end, o_crc, o_parse, o_req, o_addr} = {1'b0, ~c, ~p, ~r, ~a};
    repeat (4) @(posedge i_clk);
  endtask
  task automatic clash();
    @(posedge i_clk) #1 o_rx = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 o_rx = 1'b1;
  endtask
endmodule

// ---- mlsi_status_tb.sv ----
`timescale 1ns/1ps
module mlsi_status_tb;
  logic       i_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic       prep = 1'b0;
  logic [7:0] own = 8'h01;
  logic [7:0] a;
  logic [3:0] code = 4'h0;
  logic [2:0] d = 3'h0;
  logic [5:0] q[$];
  logic [3:0] ct[7] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h3};
  int         err_count = 0;
  int         checked = 0;
  int         k;
  int         n;
  wire        rx, st, bv, fb, fe, crc, prs, req, red, grn, abt;
  wire [7:0]  fa;
  wire [3:0]  cs;
  always #25 i_clk = ~i_clk;
  mlsi_master_model m (.i_clk(i_clk), .o_rx(rx), .o_start(st), .o_bv(bv), .o_ferr(fb),
    .o_end(fe), .o_crc(crc), .o_parse(prs), .o_req(req), .o_addr(fa));
  mlsi_status uut (.i_clk(i_clk), .i_reset(i_reset), .i_rx_line(rx), .i_own_addr(own),
    .i_byte_valid(bv), .i_byte_framing_err(fb), .i_frame_start(st), .i_frame_end(fe),
    .i_frame_addr(fa), .i_crc_ok(crc), .i_parse_ok(prs), .i_request_ok(req),
    .i_reply_prep(prep), .o_lamp_red(red), .o_lamp_green(grn), .o_exception_req(),
    .o_reply_abort(abt), .o_error_code_store(cs), .o_checksum_fail_tally(),
    .o_char_framing_fail_tally(), .o_frame_parse_fail_tally(), .o_buffer_overflow_tally());
  task automatic check(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(negedge i_clk) begin
    if (d[2]) begin
      check({2'b0, red, grn, cs}, {2'b0, q.pop_front()});
    end
    d <= {d[1:0], fe};
  end
  initial begin
    #3_000_000;
    err_count++;
    results();
  end
  initial begin
    void'($urandom(32'h19f2741a));
    own = 8'($urandom_range(247, 1));
    repeat (4) @(posedge i_clk);
    #1 i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    check({6'h00, red, grn}, 8'h00);
    repeat (40) begin
      k = $urandom_range(6, 0);
      a = (k == 1) ? own % 8'd247 + 8'd1 : own;
      if ((k == 0 || k == 5) && $urandom_range(1, 0) == 1) a = 8'h00;
      if (k > 1) code = ct[k];
      q.push_back({(k == 0 || k == 5) ? 2'b01 : (k == 1) ? 2'b11 : 2'b10, code});
      m.send(a, (k == 6) ? 257 : int'($urandom_range(8, 2)), k == 3, k != 2, k != 4, k != 5);
    end
    #1 prep = 1'b1;
    m.clash();
    n = 0;
    while (abt !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    check({7'h00, abt}, 8'h01);
    repeat (4) @(negedge i_clk);
    check({7'h00, grn}, 8'h01);
    @(posedge i_clk) #1 prep = 1'b0;
    results();
  end
endmodule
